//--- hw/urx_params.svh
/*
 Constants of the receive block: register offsets, bit positions,
 reset values and oversampling counts. Assumes a 32-bit APB map.
*/
`ifndef URX_PARAMS_SVH
`define URX_PARAMS_SVH
`define URX_OFF_DATA      8'h00
`define URX_OFF_STATUS    8'h04
`define URX_OFF_CTRL_B    8'h08
`define URX_OFF_CTRL_C    8'h0C
`define URX_STAT_RXC      7
`define URX_STAT_FERR     4
`define URX_STAT_OVR      3
`define URX_STAT_PERR     2
`define URX_STAT_DBL      1
`define URX_CTRLB_RXIE    7
`define URX_CTRLB_RECEIVER_ENABLE_BIT    4
`define URX_CTRLB_MASK    8'h90
`define URX_CTRLC_PEN     5
`define URX_CTRLC_PODD    4
`define URX_CTRLC_STOP2   3
`define URX_CTRLC_MASK    8'h3E
`define URX_CTRLB_RST     8'h00
`define URX_CTRLC_RST     8'h06
`define URX_DBL_RST       1'b0
`define URX_ENT_W         11
`define URX_ENT_FERR      8
`define URX_ENT_OVR       9
`define URX_ENT_PERR      10
`define URX_SPB_NORM      5'h10
`define URX_SPB_DBL       5'h08
`define URX_MIN_BITS      3'h4
`endif

//--- hw/urx_pkg.sv
/*
 Types and shared helpers of the receive block.
 Assumes urx_params.svh is included by the users of the constants.
*/
package urx_pkg;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } urx_state_t;

  // Two of three wins
  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction : majority
endpackage : urx_pkg

//--- hw/urx_sync.sv
/*
 Two-stage synchroniser for the receive pin.
 Assumes an idle-high line; resets to the idle level.
*/
`timescale 1ns/1ps
`default_nettype none
module urx_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Pin in, synchronised out
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b1;
      q      <= 1'b1;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : urx_sync
`default_nettype wire

//--- hw/urx_fifo.sv
/*
 Two-entry receive buffer holding a character with its error flags.
 Assumes the caller never pushes while full.
*/
`timescale 1ns/1ps
`default_nettype none
`include "urx_params.svh"
module urx_fifo (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  // Control
  input  wire logic                 flush,
  input  wire logic                 push,
  input  wire logic [`URX_ENT_W-1:0] push_data,
  input  wire logic                 pop,
  // State
  output logic [`URX_ENT_W-1:0]     head,
  output logic                      empty,
  output logic                      full
);
  logic [`URX_ENT_W-1:0] mem [2];
  logic                  wp_q;
  logic                  rp_q;
  logic [1:0]            cnt_q;

  assign empty = (cnt_q == 2'h0);
  assign full  = (cnt_q == 2'h2);
  assign head  = empty ? '0 : mem[rp_q];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else if (ce) begin
      if (flush) begin
        wp_q  <= 1'b0;
        rp_q  <= 1'b0;
        cnt_q <= 2'h0;
      end else begin
        if (push && !full)
          wp_q <= ~wp_q;
        if (pop && !empty)
          rp_q <= ~rp_q;
        cnt_q <= cnt_q + {1'b0, push && !full} - {1'b0, pop && !empty};
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (ce && push && !full && !flush)
      mem[wp_q] <= push_data;
  end

  a_fifo_no_overfill:
    assert property (@(posedge pclk) disable iff (!presetn)
      ce && full && !pop && !flush |=> full)
    else $error("buffer lost an entry while full");
endmodule : urx_fifo
`default_nettype wire

//--- hw/urx_top.sv
/*
 Receive side of a serial port: start detection by oversampling,
 majority voting, parity check, two-entry buffer with error flags,
 APB register access and the receive-complete interrupt request.
 Assumes sample_tick pulses one pclk cycle at 16x (or 8x) baud and
 comes from logic on pclk; rxd comes from the pin.
*/
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "urx_params.svh"
module urx_top (
  // Clock, reset, clock enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial side
  input  wire logic        rxd,
  input  wire logic        sample_tick,
  output logic             rxd_owned,
  // Interrupt
  input  wire logic        global_irq_en,
  output logic             rx_irq
);
  urx_pkg::urx_state_t    st_q;
  logic [7:0]             ctrl_b_q;
  logic [7:0]             ctrl_c_q;
  logic                   dbl_q;
  logic                   ack_q;
  logic                   rxd_s;
  logic                   prev_q;
  logic [4:0]             cnt_q;
  logic [2:0]             bidx_q;
  logic [1:0]             v_q;
  logic [7:0]             sh_q;
  logic                   pbit_q;
  logic                   pen_q;
  logic                   done_q;
  logic [`URX_ENT_W-1:0]  new_q;
  logic [`URX_ENT_W-1:0]  hold_ent_q;
  logic                   hold_q;
  logic                   ovr_pend_q;
  logic [`URX_ENT_W-1:0]  head;
  logic [`URX_ENT_W-1:0]  push_data;
  logic                   fifo_empty;
  logic                   fifo_full;

  // Bus decode
  logic rx_en;
  logic acc;
  logic xfer;
  logic mapped;
  logic pop;
  logic wr_stat;
  assign rx_en  = ctrl_b_q[`URX_CTRLB_RECEIVER_ENABLE_BIT];
  assign acc    = psel && penable;
  assign xfer   = acc && ack_q;
  assign mapped = (paddr == `URX_OFF_DATA) || (paddr == `URX_OFF_STATUS) ||
                  (paddr == `URX_OFF_CTRL_B) || (paddr == `URX_OFF_CTRL_C);
  assign pready  = ack_q;
  assign pslverr = ack_q && !mapped;
  assign pop     = ce && xfer && !pwrite && (paddr == `URX_OFF_DATA);
  assign wr_stat = ce && xfer && pwrite && (paddr == `URX_OFF_STATUS);

  // Sampling geometry
  logic [4:0] spb;
  logic [4:0] vote_first;
  logic [4:0] vote_last;
  logic [2:0] last_bit;
  logic       tk;
  logic       vote_now;
  logic       start_edge;
  assign spb        = dbl_q ? `URX_SPB_DBL : `URX_SPB_NORM;
  assign vote_first = spb >> 1;
  assign vote_last  = vote_first + 5'h02;
  assign last_bit   = {1'b0, ctrl_c_q[2:1]} + `URX_MIN_BITS;
  assign tk         = ce && rx_en && sample_tick;
  assign vote_now   = urx_pkg::majority({v_q, rxd_s});
  assign start_edge = tk && (st_q == urx_pkg::RX_IDLE) && prev_q && !rxd_s;

  urx_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (rxd),
    .q       (rxd_s)
  );

  // Registers and the one-wait-state answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= acc && !ack_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b_q <= `URX_CTRLB_RST;
      ctrl_c_q <= `URX_CTRLC_RST;
      dbl_q    <= `URX_DBL_RST;
    end else if (ce && xfer && pwrite) begin
      if (paddr == `URX_OFF_CTRL_B)
        ctrl_b_q <= pwdata[7:0] & `URX_CTRLB_MASK;
      if (paddr == `URX_OFF_CTRL_C)
        ctrl_c_q <= pwdata[7:0] & `URX_CTRLC_MASK;
      // Only the speed bit is writable here; error flags ignore writes
      if (wr_stat)
        dbl_q <= pwdata[`URX_STAT_DBL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && acc && !ack_q) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        `URX_OFF_DATA:   prdata[7:0] <= head[7:0];
        `URX_OFF_STATUS: begin
          prdata[`URX_STAT_RXC]  <= !fifo_empty;
          prdata[`URX_STAT_FERR] <= head[`URX_ENT_FERR];
          prdata[`URX_STAT_OVR]  <= head[`URX_ENT_OVR];
          prdata[`URX_STAT_PERR] <= head[`URX_ENT_PERR];
          prdata[`URX_STAT_DBL]  <= dbl_q;
        end
        `URX_OFF_CTRL_B: prdata[7:0] <= ctrl_b_q;
        `URX_OFF_CTRL_C: prdata[7:0] <= ctrl_c_q;
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Start detection and bit recovery
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b1;
    end else if (ce && (sample_tick || !rx_en)) begin
      prev_q <= rx_en && rxd_s; // Low while off avoids a false start
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= urx_pkg::RX_IDLE;
      cnt_q  <= 5'h00;
      bidx_q <= 3'h0;
      v_q    <= 2'h0;
    end else if (ce) begin
      if (!rx_en) begin
        st_q  <= urx_pkg::RX_IDLE;
        cnt_q <= 5'h00;
      end else if (tk) begin
        if (st_q == urx_pkg::RX_IDLE) begin
          if (start_edge) begin
            st_q  <= urx_pkg::RX_START;
            cnt_q <= 5'h02; // Counts the sample the next tick takes
          end
        end else begin
          cnt_q <= (cnt_q == spb) ? 5'h01 : cnt_q + 5'h01;
          if (cnt_q >= vote_first && cnt_q < vote_last)
            v_q <= {v_q[0], rxd_s};
          if (cnt_q == vote_last) begin
            unique case (st_q)
              urx_pkg::RX_START: begin
                // Noise spikes shorter than half a bit are dropped
                st_q   <= vote_now ? urx_pkg::RX_IDLE
                                   : urx_pkg::RX_DATA;
                bidx_q <= 3'h0;
              end
              urx_pkg::RX_DATA: begin
                bidx_q <= bidx_q + 3'h1;
                if (bidx_q == last_bit)
                  st_q <= ctrl_c_q[`URX_CTRLC_PEN] ? urx_pkg::RX_PAR
                                                   : urx_pkg::RX_STOP;
              end
              urx_pkg::RX_PAR:  st_q <= urx_pkg::RX_STOP;
              // Ending at the centre lets the next start follow at once
              urx_pkg::RX_STOP: st_q <= urx_pkg::RX_IDLE;
              default:          st_q <= urx_pkg::RX_IDLE;
            endcase
          end
        end
      end
    end
  end

  // Frame assembly
  logic decide;
  logic perr_c;
  assign decide = tk && (st_q != urx_pkg::RX_IDLE) && (cnt_q == vote_last);
  assign perr_c = pen_q &&
                  ((^sh_q ^ pbit_q) != ctrl_c_q[`URX_CTRLC_PODD]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q   <= 8'h00;
      pbit_q <= 1'b0;
      pen_q  <= 1'b0;
      done_q <= 1'b0;
      new_q  <= '0;
    end else if (ce) begin
      done_q <= 1'b0;
      if (start_edge)
        sh_q <= 8'h00;
      if (decide && st_q == urx_pkg::RX_DATA) begin
        sh_q[bidx_q] <= vote_now;
        if (bidx_q == last_bit)
          pen_q <= ctrl_c_q[`URX_CTRLC_PEN];
      end
      if (decide && st_q == urx_pkg::RX_PAR)
        pbit_q <= vote_now;
      if (decide && st_q == urx_pkg::RX_STOP) begin
        done_q                <= 1'b1;
        new_q[7:0]            <= sh_q;
        new_q[`URX_ENT_FERR]  <= !vote_now;
        new_q[`URX_ENT_OVR]   <= 1'b0;
        new_q[`URX_ENT_PERR]  <= perr_c;
      end
    end
  end

  // Shift-register hold stage and overrun
  logic push_hold;
  logic push_new;
  logic push;
  logic ovr_event;
  assign push_hold = hold_q && !fifo_full;
  assign push_new  = done_q && !hold_q && !fifo_full;
  assign push      = rx_en && (push_hold || push_new);
  assign ovr_event = start_edge && hold_q && fifo_full;

  always_comb begin
    push_data              = push_hold ? hold_ent_q : new_q;
    push_data[`URX_ENT_OVR] = ovr_pend_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q     <= 1'b0;
      hold_ent_q <= '0;
      ovr_pend_q <= 1'b0;
    end else if (ce) begin
      if (!rx_en) begin
        hold_q     <= 1'b0;
        ovr_pend_q <= 1'b0;
      end else begin
        if (done_q && !push_new) begin
          hold_q     <= 1'b1;
          hold_ent_q <= new_q;
        end else if (push_hold || ovr_event) begin
          hold_q <= 1'b0;
        end
        if (ovr_event)
          ovr_pend_q <= 1'b1;
        else if (push)
          ovr_pend_q <= 1'b0;
      end
    end
  end

  urx_fifo u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .flush     (!rx_en),
    .push      (push),
    .push_data (push_data),
    .pop       (pop),
    .head      (head),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );

  // Pin ownership and interrupt request
  assign rxd_owned = rx_en;
  assign rx_irq    = ctrl_b_q[`URX_CTRLB_RXIE] && global_irq_en &&
                     !fifo_empty;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_enable_drop;
    ce && !rx_en;
  endsequence

  sequence s_first_entry;
    ce && push && fifo_empty && rx_en;
  endsequence

  a_rxc_on_push:
    assert property (s_first_entry |=> !fifo_empty)
    else $error("complete flag missing after first entry");

  a_flush_on_off:
    assert property (s_enable_drop |=> fifo_empty && !rx_irq)
    else $error("buffer not flushed on disable");

  a_irq_level:
    assert property (!fifo_empty && ctrl_b_q[`URX_CTRLB_RXIE] &&
                     global_irq_en |-> rx_irq)
    else $error("interrupt not requested");

  a_no_err_irq:
    assert property (rx_irq |-> !fifo_empty && ctrl_b_q[`URX_CTRLB_RXIE])
    else $error("interrupt without data");

  a_head_stable:
    assert property (ce && wr_stat && !push |=> $stable(head))
    else $error("status write changed buffered flags");

  a_stop_frame_err:
    assert property (decide && st_q == urx_pkg::RX_STOP |=>
                     done_q && new_q[`URX_ENT_FERR] == !$past(vote_now))
    else $error("frame error does not follow stop bit");

  a_parity_off:
    assert property (done_q && !pen_q |-> !new_q[`URX_ENT_PERR])
    else $error("parity error with checking off");

  a_start_reject:
    assert property (decide && st_q == urx_pkg::RX_START && vote_now
                     |=> st_q == urx_pkg::RX_IDLE)
    else $error("noisy start not rejected");

  a_overrun_set:
    assert property (ce && ovr_event && rx_en |=> ovr_pend_q && !hold_q)
    else $error("overrun not recorded");

  a_idle_on_off:
    assert property (s_enable_drop |=> (st_q == urx_pkg::RX_IDLE) [*2])
    else $error("receiver not idle after disable");
endmodule : urx_top
`default_nettype wire

//--- tb/urx_tx_model.sv
/*
 Remote serial transmitter model that drives the receive line.
 Assumes sample_tick pulses once per oversample, in the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module urx_tx_model (
  // Clock and oversample tick
  input  wire logic pclk,
  input  wire logic sample_tick,
  // Serial line, idle high
  output var logic  rxd
);
  initial rxd = 1'b1;

  // Levels change just after a tick, so every bit spans whole ticks
  task automatic hold(input logic v, input int n);
    rxd <= v;
    repeat (n) @(posedge pclk iff sample_tick);
  endtask : hold

  // LSB first; pb[1] adds parity bit pb[0]; one idle bit closes it
  task automatic send(input logic [7:0] d, input int nb, input int spb,
                      input logic [1:0] pb, input logic stp);
    @(posedge pclk iff sample_tick);
    hold(1'b0, spb);
    for (int i = 0; i < nb; i++)
      hold(d[i], spb);
    if (pb[1])
      hold(pb[0], spb);
    hold(stp, spb);
    hold(1'b1, spb);
  endtask : send
endmodule : urx_tx_model
`default_nettype wire

//--- tb/test_uart_receiver_status_and_start_detect.sv
/*
 Self-checking bench of the receive block: APB master, tick maker
 and a remote transmitter model on the receive line.
 Assumes the register map and bit positions of urx_params.svh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "urx_params.svh"
module test_uart_receiver_status_and_start_detect;
  localparam logic [7:0] DAT = `URX_OFF_DATA;
  localparam logic [7:0] STA = `URX_OFF_STATUS;
  localparam logic [7:0] CB  = `URX_OFF_CTRL_B;
  localparam logic [7:0] CC  = `URX_OFF_CTRL_C;
  logic        pclk, presetn, ce, psel, penable, pwrite;
  logic        pready, pslverr, rxd_owned, rx_irq, global_irq_en, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [1:0]  tcnt = 2'h0;
  wire         sample_tick;
  wire         rxd;
  int          fail_count, n_checks;

  // Tick every fourth clock keeps frames short
  always @(posedge pclk)
    tcnt <= tcnt + 2'h1;
  assign sample_tick = (tcnt == 2'h3);

  urx_top i_urx_top (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .sample_tick(sample_tick),
    .rxd_owned(rxd_owned), .global_irq_en(global_irq_en),
    .rx_irq(rx_irq)
  );
  urx_tx_model i_urx_tx_model (
    .pclk(pclk), .sample_tick(sample_tick), .rxd(rxd)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] st(input logic c, f, o, p);
    st = 32'h0;
    st[`URX_STAT_RXC] = c;
    st[`URX_STAT_FERR] = f;
    st[`URX_STAT_OVR] = o;
    st[`URX_STAT_PERR] = p;
  endfunction : st

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Entered just after an edge; leaves one idle edge after release
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask : rd

  task automatic tx(input logic [7:0] d, input logic s);
    i_urx_tx_model.send(d, 8, 16, 2'b00, s);
  endtask : tx

  task automatic t_reset;
    rd(CB, {24'h0, `URX_CTRLB_RST});
    rd(CC, {24'h0, `URX_CTRLC_RST});
    rd(STA, st(0, 0, 0, 0));
    chk({31'h0, rxd_owned}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rdv, 32'h0);
  endtask : t_reset

  task automatic t_basic;
    wr(CB, 32'h10);
    chk({31'h0, rxd_owned}, 32'h1);
    tx(8'hA5, 1'b1);
    rd(STA, st(1, 0, 0, 0));
    rd(DAT, 32'hA5);
    rd(STA, st(0, 0, 0, 0));
  endtask : t_basic

  task automatic t_flags;
    tx(8'h3C, 1'b0);
    tx(8'h5A, 1'b1);
    wr(STA, 32'h1C);
    rd(STA, st(1, 1, 0, 0));
    rd(DAT, 32'h3C);
    rd(STA, st(1, 0, 0, 0));
    rd(DAT, 32'h5A);
  endtask : t_flags

  // Two stop bits selected but one sent: stop count must not matter
  task automatic t_parity;
    logic p;
    for (int m = 0; m < 2; m++) begin
      wr(CC, 32'h2E | (32'(m) << 4));
      p = (^8'h37) ^ m[0];
      i_urx_tx_model.send(8'h37, 8, 16, {1'b1, p}, 1'b1);
      i_urx_tx_model.send(8'h37, 8, 16, {1'b1, ~p}, 1'b1);
      wr(CC, 32'h06);
      rd(STA, st(1, 0, 0, 0));
      rd(DAT, 32'h37);
      rd(STA, st(1, 0, 0, 1));
      rd(DAT, 32'h37);
    end
    wr(CC, 32'h08);
    i_urx_tx_model.send(8'hFF, 5, 16, 2'b00, 1'b1);
    rd(STA, st(1, 0, 0, 0));
    rd(DAT, 32'h1F);
    wr(CC, 32'h06);
  endtask : t_parity

  task automatic t_overrun;
    for (int i = 1; i < 5; i++)
      tx(8'(i * 17), 1'b1);
    rd(STA, st(1, 0, 0, 0));
    rd(DAT, 32'h11);
    rd(STA, st(1, 0, 0, 0));
    rd(DAT, 32'h22);
    rd(STA, st(1, 0, 1, 0));
    rd(DAT, 32'h44);
    tx(8'h55, 1'b1);
    rd(STA, st(1, 0, 0, 0));
    rd(DAT, 32'h55);
  endtask : t_overrun

  // Idle long enough that a wrongly taken start would finish a frame
  task automatic t_noise;
    i_urx_tx_model.hold(1'b0, 7);
    i_urx_tx_model.hold(1'b1, 170);
    rd(STA, st(0, 0, 0, 0));
    tx(8'h96, 1'b1);
    rd(DAT, 32'h96);
    wr(STA, 32'h02);
    rd(STA, 32'h02);
    i_urx_tx_model.hold(1'b0, 3);
    i_urx_tx_model.hold(1'b1, 90);
    i_urx_tx_model.send(8'hC3, 8, 8, 2'b00, 1'b1);
    rd(STA, 32'h82);
    rd(DAT, 32'hC3);
    wr(STA, 32'h00);
  endtask : t_noise

  task automatic t_irq;
    global_irq_en <= 1'b1;
    tx(8'h0F, 1'b0);
    wr(CB, 32'h90);
    chk({31'h0, rx_irq}, 32'h1);
    global_irq_en <= 1'b0;
    @(posedge pclk);
    chk({31'h0, rx_irq}, 32'h0);
    global_irq_en <= 1'b1;
    rd(DAT, 32'h0F);
    chk({31'h0, rx_irq}, 32'h0);
    wr(CB, 32'h10);
  endtask : t_irq

  task automatic t_disable;
    tx(8'h81, 1'b1);
    fork
      tx(8'h42, 1'b1);
      begin
        repeat (150) @(posedge pclk);
        wr(CB, 32'h00);
        chk({31'h0, rxd_owned}, 32'h0);
        rd(STA, st(0, 0, 0, 0));
      end
    join
    wr(CB, 32'h10);
    tx(8'h24, 1'b1);
    rd(STA, st(1, 0, 0, 0));
    rd(DAT, 32'h24);
    rd(STA, st(0, 0, 0, 0));
  endtask : t_disable

  // A low clock enable must hold off the bus answer and the pop
  task automatic t_ce;
    tx(8'h6B, 1'b1);
    ce <= 1'b0;
    fork
      rd(DAT, 32'h6B);
      begin
        repeat (20) @(posedge pclk);
        chk({31'h0, psel}, 32'h1);
        ce <= 1'b1;
      end
    join
    rd(STA, st(0, 0, 0, 0));
  endtask : t_ce

  task automatic end_sim;
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    global_irq_en = 1'b0;
    fail_count = 0;
    n_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_basic;
    t_flags;
    t_parity;
    t_overrun;
    t_noise;
    t_irq;
    t_disable;
    t_ce;
    end_sim;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    end_sim;
  end
endmodule : test_uart_receiver_status_and_start_detect
`default_nettype wire
